//--- verilog/wdl_defs.svh
// Constants of the watchdog lock and status block.
// Assumes inclusion by bare name.
//
// Behaviour
// R01: Period codes 0x6..0xB give 256, 512, 1K, 2K, 4K, 8K watchdog clock cycles.
// R02: Software never programs period codes above 0xB; those are reserved.
// R03: While lock is one, every write to the control register is ignored.
// R04: Software can only set lock; writing zero leaves it unchanged. The code clears it on a keyed zero write while in debug mode.
// R05: Lock is cleared only while in debug mode.
// R06: Non-zero period after boot completes sets lock automatically.
// R07: Lock-setting write counts only right after the unlock key write.
// R08: Any control write sets busy (bit 0) while it crosses domains; the code sets it only for a keyed write taken while unlocked and not busy.
// R09: Busy clears itself once the transfer completes; software cannot clear it.
// R10: Busy is read-only and independent of the unlock sequence; the code sets it only for a control write inside the unlock window.
// R11: Software polls busy and never writes control while it reads one.
// R12: Restart takes two to three watchdog cycles; repeats meanwhile are ignored.
// R13: Software writes the unlock key, then the protected write shortly after.
// R14: Non-zero period enables the watchdog; zero leaves it off.
// R15: Debug-mode input must be high for a lock-clearing write.
`ifndef WDL_DEFS_SVH
`define WDL_DEFS_SVH

// Register indices; byte address is four times the index
`define WDL_IDX_CTRL     2'h0
`define WDL_IDX_STATUS   2'h1
`define WDL_IDX_UNLOCK   2'h2
`define WDL_IDX_RESTART  2'h3

// Field positions
`define WDL_PERIOD_LSB   0
`define WDL_PERIOD_MSB   3
`define WDL_WINDOW_LSB   4
`define WDL_WINDOW_MSB   7
`define WDL_LOCK_BIT     7
`define WDL_BUSY_BIT     0

// Reset values
`define WDL_STATUS_RST   8'h00

// Period decode: code 0x1 is 8 cycles, each code doubles
`define WDL_TO_MIN_CYC   14'h0008
`define WDL_CODE_MAX     4'hb

// Transfer into the watchdog domain, in watchdog clock ticks
`define WDL_SYNC_TICKS   2'h2

// Unlock key (arbitrary value) and its validity in system clock cycles
`define WDL_UNLOCK_KEY   8'h5a
`define WDL_UNLOCK_CYC   3'h4

// Bus responses
`define WDL_RESP_OKAY    2'h0
`define WDL_RESP_SLVERR  2'h2

`endif

//--- verilog/wdl_pkg.sv
// Types shared by the watchdog lock and status block.
// Assumes the constants header sits beside it.
`include "wdl_defs.svh"

package wdl_pkg;
    // Watchdog counting phase, one-hot
    typedef enum logic [2:0] {
        WDL_PH_OFF    = 3'b001,
        WDL_PH_CLOSED = 3'b010,
        WDL_PH_OPEN   = 3'b100
    } wdl_phase_e;

    typedef logic [13:0] wdl_count_t;
endpackage

//--- verilog/wdl_sync3.sv
// Three-stage synchroniser with agreement filter, one per bit.
// Assumes inputs async to clk_i; output is a level on clk_i.
`timescale 1ns/1ns

module wdl_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] level_o
);

    ////////////////////////////////////////
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            logic lvl_next;

            // Change counts only once stages two and three agree
            always_comb begin
                lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
            end

            // First stage feeds only the second one
            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    s1_reg  <= 1'b0;
                    s2_reg  <= 1'b0;
                    s3_reg  <= 1'b0;
                    lvl_reg <= 1'b0;
                end else begin
                    s1_reg  <= async_i[gi];
                    s2_reg  <= s1_reg;
                    s3_reg  <= s2_reg;
                    lvl_reg <= lvl_next;
                end
            end

            assign level_o[gi] = lvl_reg;
        end
    endgenerate

endmodule

//--- verilog/wdl_watchdog_lock.sv
// Watchdog control, lock, sync busy flag and timeout counter.
// Assumes an AXI4-Lite master on clk_i; other pins are async, the fuse static.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "wdl_defs.svh"

module wdl_watchdog_lock
    import wdl_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    input  wire logic              wdt_clk_i,
    input  wire logic              debug_mode_i,
    input  wire logic              boot_done_i,
    input  wire logic [7:0]        fuse_ctrl_i,
    output logic                   wdt_reset_o,
    output logic                   lock_o
);

    ////////////////////////////////////////
    // Pin synchronisers
    logic       wclk_lvl;
    logic       dbg_lvl;
    logic       boot_lvl;

    wdl_sync3 #(
        .WIDTH (3)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .async_i ({boot_done_i, debug_mode_i, wdt_clk_i}),
        .level_o ({boot_lvl, dbg_lvl, wclk_lvl})
    );

    ////////////////////////////////////////
    // AXI4-Lite slave
    logic              awready_reg, awready_next;
    logic              wready_reg,  wready_next;
    logic              aw_held_reg, aw_held_next;
    logic              w_held_reg,  w_held_next;
    logic [ADDR_W-1:0] waddr_reg,   waddr_next;
    logic [7:0]        wdata_reg,   wdata_next;
    logic              wstrb_reg,   wstrb_next;
    logic              bvalid_reg,  bvalid_next;
    logic [1:0]        bresp_reg,   bresp_next;
    logic              arready_reg, arready_next;
    logic              rvalid_reg,  rvalid_next;
    logic [7:0]        rdata_reg,   rdata_next;
    logic [1:0]        rresp_reg,   rresp_next;
    logic              do_write;
    logic              w_mapped;
    logic [1:0]        w_idx;
    logic              r_mapped;
    logic [1:0]        r_idx;
    logic [7:0]        ctrl_reg;
    logic              lock_reg;
    logic              busy_reg;

    // Address decode; four words mapped
    assign w_idx    = waddr_reg[3:2];
    assign w_mapped = (waddr_reg >> 4) == '0;
    assign r_idx    = s_axi_araddr_i[3:2];
    assign r_mapped = (s_axi_araddr_i >> 4) == '0;
    // Commit once both halves are held and no answer pends
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

    // Bus next state; address and data in either order
    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next  = w_held_reg;
        waddr_next   = waddr_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg && !s_axi_bready_i;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg && !s_axi_rready_i;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (s_axi_awvalid_i && awready_reg) begin
            aw_held_next = 1'b1;
            waddr_next   = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && wready_reg) begin
            w_held_next = 1'b1;
            wdata_next  = s_axi_wdata_i[7:0];
            wstrb_next  = s_axi_wstrb_i[0];
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = w_mapped ? `WDL_RESP_OKAY : `WDL_RESP_SLVERR;
        end
        if (s_axi_arvalid_i && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next  = r_mapped ? `WDL_RESP_OKAY : `WDL_RESP_SLVERR;
            rdata_next  = 8'h00;
            if (r_mapped && r_idx == `WDL_IDX_CTRL) begin
                rdata_next = ctrl_reg;
            end else if (r_mapped && r_idx == `WDL_IDX_STATUS) begin
                rdata_next = {lock_reg, 6'h00, busy_reg};
            end
        end
        awready_next = !aw_held_next;
        wready_next  = !w_held_next;
        arready_next = !rvalid_next;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            waddr_reg   <= '0;
            wdata_reg   <= 8'h00;
            wstrb_reg   <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `WDL_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 8'h00;
            rresp_reg   <= `WDL_RESP_OKAY;
        end else begin
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
            aw_held_reg <= aw_held_next;
            w_held_reg  <= w_held_next;
            waddr_reg   <= waddr_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    assign s_axi_awready_o = awready_reg;
    assign s_axi_wready_o  = wready_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;
    assign s_axi_arready_o = arready_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rresp_o   = rresp_reg;
    assign s_axi_rdata_o   = {24'h000000, rdata_reg};

    ////////////////////////////////////////
    // Configuration, lock, unlock window and domain transfer
    logic       wr_hit;
    logic       wclk_prev_reg;
    logic       tick;
    logic       loaded_reg,  loaded_next;
    logic [7:0] ctrl_next;
    logic [7:0] act_reg,     act_next;
    logic       lock_next;
    logic       busy_next;
    logic [1:0] scnt_reg,    scnt_next;
    logic [2:0] ucnt_reg,    ucnt_next;
    logic       rpend_reg,   rpend_next;
    logic [1:0] rcnt_reg,    rcnt_next;
    logic       boot_prev_reg;
    logic       restart_done;

    assign wr_hit = do_write && w_mapped && wstrb_reg;
    // One tick per filtered rising edge of the watchdog clock pin
    assign tick = wclk_lvl && !wclk_prev_reg;
    assign restart_done = rpend_reg && tick && (rcnt_reg == `WDL_SYNC_TICKS - 2'h1); // R12

    // Config next state; later assignments win
    always_comb begin
        loaded_next = 1'b1;
        ctrl_next   = ctrl_reg;
        act_next    = act_reg;
        lock_next   = lock_reg;
        busy_next   = busy_reg;
        scnt_next   = scnt_reg;
        ucnt_next   = (ucnt_reg != 3'h0) ? ucnt_reg - 3'h1 : 3'h0;
        rpend_next  = rpend_reg;
        rcnt_next   = rcnt_reg;
        // Strap caught right after reset
        if (!loaded_reg) begin
            ctrl_next = fuse_ctrl_i;
            act_next  = fuse_ctrl_i;
        end
        // Transfer completes on the second watchdog tick
        if (busy_reg && tick) begin
            if (scnt_reg == `WDL_SYNC_TICKS - 2'h1) begin
                act_next  = ctrl_reg;
                busy_next = 1'b0; // R09
            end else begin
                scnt_next = scnt_reg + 2'h1;
            end
        end
        if (rpend_reg && tick) rcnt_next = rcnt_reg + 2'h1;
        if (restart_done) rpend_next = 1'b0;
        if (wr_hit && w_idx == `WDL_IDX_UNLOCK && wdata_reg == `WDL_UNLOCK_KEY) begin
            ucnt_next = `WDL_UNLOCK_CYC;
        end
        // Busy is set only by a control write inside the unlock window
        if (wr_hit && w_idx == `WDL_IDX_CTRL) begin
            ucnt_next = 3'h0;
            // Dropped while busy, keeping the crossing coherent
            if (ucnt_reg != 3'h0 && !lock_reg && !busy_reg) begin // R03 R07
                ctrl_next = wdata_reg;
                busy_next = 1'b1; // R08 R10
                scnt_next = 2'h0;
            end
        end
        if (wr_hit && w_idx == `WDL_IDX_STATUS) begin
            ucnt_next = 3'h0;
            if (ucnt_reg != 3'h0) begin // R07
                if (wdata_reg[`WDL_LOCK_BIT]) begin
                    lock_next = 1'b1; // R04
                end else if (dbg_lvl) begin
                    lock_next = 1'b0; // R05 R15
                end
            end
        end
        // Repeats ignored while one synchronises
        if (wr_hit && w_idx == `WDL_IDX_RESTART && !rpend_reg) begin // R12
            rpend_next = 1'b1;
            rcnt_next  = 2'h0;
        end
        // Boot with a running period locks; set wins
        if (boot_lvl && !boot_prev_reg &&
            ctrl_reg[`WDL_PERIOD_MSB:`WDL_PERIOD_LSB] != 4'h0) begin
            lock_next = 1'b1; // R06
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            loaded_reg    <= 1'b0;
            ctrl_reg      <= 8'h00;
            act_reg       <= 8'h00;
            lock_reg      <= 1'(`WDL_STATUS_RST >> `WDL_LOCK_BIT);
            busy_reg      <= 1'b0;
            scnt_reg      <= 2'h0;
            ucnt_reg      <= 3'h0;
            rpend_reg     <= 1'b0;
            rcnt_reg      <= 2'h0;
            boot_prev_reg <= 1'b0;
        end else begin
            loaded_reg    <= loaded_next;
            ctrl_reg      <= ctrl_next;
            act_reg       <= act_next;
            lock_reg      <= lock_next;
            busy_reg      <= busy_next;
            scnt_reg      <= scnt_next;
            ucnt_reg      <= ucnt_next;
            rpend_reg     <= rpend_next;
            rcnt_reg      <= rcnt_next;
            boot_prev_reg <= boot_lvl;
        end
    end

    ////////////////////////////////////////
    // Timeout counter in watchdog ticks
    wdl_phase_e phase_reg, phase_next;
    wdl_count_t cnt_reg,   cnt_next;
    logic       fire_reg,  fire_next;
    wdl_count_t lim_per;
    wdl_count_t lim_win;

    // Reserved codes decode to zero (off)
    function automatic wdl_count_t wdl_limit(input logic [3:0] code);
        wdl_count_t lim;
        lim = '0;
        if (code != 4'h0 && code <= `WDL_CODE_MAX) begin
            lim = `WDL_TO_MIN_CYC << (code - 4'h1); // R01
        end
        return lim;
    endfunction

    assign lim_per = wdl_limit(act_reg[`WDL_PERIOD_MSB:`WDL_PERIOD_LSB]);
    assign lim_win = wdl_limit(act_reg[`WDL_WINDOW_MSB:`WDL_WINDOW_LSB]);

    // Debug halt clears the counter; a restart starts the closed window if one is set
    always_comb begin
        phase_next = phase_reg;
        cnt_next   = cnt_reg;
        fire_next  = 1'b0;
        if (lim_per == '0 || dbg_lvl) begin // R14
            phase_next = WDL_PH_OFF;
            cnt_next   = '0;
        end else begin
            unique case (phase_reg)
                WDL_PH_OFF: begin
                    phase_next = WDL_PH_OPEN;
                    cnt_next   = '0;
                end
                WDL_PH_OPEN: begin
                    if (restart_done) begin
                        cnt_next   = '0;
                        phase_next = (lim_win != '0) ? WDL_PH_CLOSED : WDL_PH_OPEN;
                    end else if (tick) begin
                        if (cnt_reg + 14'h0001 >= lim_per) begin
                            fire_next = 1'b1;
                            cnt_next  = '0;
                        end else begin
                            cnt_next = cnt_reg + 14'h0001;
                        end
                    end
                end
                WDL_PH_CLOSED: begin
                    // Restart too early is as bad as none at all
                    if (restart_done) begin
                        fire_next  = 1'b1;
                        cnt_next   = '0;
                        phase_next = WDL_PH_OPEN;
                    end else if (tick) begin
                        if (cnt_reg + 14'h0001 >= lim_win) begin
                            cnt_next   = '0;
                            phase_next = WDL_PH_OPEN;
                        end else begin
                            cnt_next = cnt_reg + 14'h0001;
                        end
                    end
                end
                default: begin
                    phase_next = WDL_PH_OFF;
                    cnt_next   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_reg     <= WDL_PH_OFF;
            cnt_reg       <= '0;
            fire_reg      <= 1'b0;
            wclk_prev_reg <= 1'b0;
        end else begin
            phase_reg     <= phase_next;
            cnt_reg       <= cnt_next;
            fire_reg      <= fire_next;
            wclk_prev_reg <= wclk_lvl;
        end
    end

    assign wdt_reset_o = fire_reg;
    assign lock_o      = lock_reg;

endmodule

//--- testbench/wdl_watchdog_lock_checker.sv
// Checker: bus answers, lock and busy flags.
// Assumes the bind below; all on clk_i.
`timescale 1ns/1ns
`include "wdl_defs.svh"

module wdl_watchdog_lock_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic              clk_i,
    input wire logic              rst_b_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic              s_axi_awvalid_i,
    input wire logic              s_axi_awready_o,
    input wire logic [1:0]        s_axi_bresp_o,
    input wire logic              s_axi_bvalid_o,
    input wire logic              s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic              s_axi_arvalid_i,
    input wire logic              s_axi_arready_o,
    input wire logic [31:0]       s_axi_rdata_o,
    input wire logic              s_axi_rvalid_o,
    input wire logic              debug_mode_i,
    input wire logic              boot_done_i,
    input wire logic              wdt_reset_o,
    input wire logic              lock_o
);
    localparam logic [ADDR_W-1:0] STA_A = ADDR_W'({`WDL_IDX_STATUS, 2'h0});

    ////////////////////////////////////////
    // Read target, write target, cycles since a write answer
    logic       rd_stat_reg, rd_stat_next;
    logic       wr_bad_reg, wr_bad_next;
    logic [5:0] since_b_reg, since_b_next;

    always_comb begin
        rd_stat_next = rd_stat_reg;
        wr_bad_next  = wr_bad_reg;
        since_b_next = since_b_reg + {5'h0, since_b_reg != 6'h3f}; // Saturates
        if (s_axi_arvalid_i && s_axi_arready_o) rd_stat_next = s_axi_araddr_i == STA_A;
        if (s_axi_awvalid_i && s_axi_awready_o) wr_bad_next = s_axi_awaddr_i >= ADDR_W'(16);
        if (s_axi_bvalid_o && s_axi_bready_i) since_b_next = 6'h00;
    end

    // Helper state
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_stat_reg <= 1'b0;
            wr_bad_reg  <= 1'b0;
            since_b_reg <= 6'h00;
        end else begin
            rd_stat_reg <= rd_stat_next;
            wr_bad_reg  <= wr_bad_next;
            since_b_reg <= since_b_next;
        end
    end

    ////////////////////////////////////////
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_stat_rd;
        s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == STA_A;
    endsequence

    a_stat_lock: assert property (s_stat_rd |=> s_axi_rdata_o[7] == $past(lock_o))
        else $error("status lock bit wrong");
    a_stat_zero: assert property (s_stat_rd |=> s_axi_rdata_o[31:8] == 24'h0 &&
        s_axi_rdata_o[6:1] == 6'h00)
        else $error("status unused bits not zero");
    a_busy_end: assert property (s_axi_rvalid_o && rd_stat_reg && s_axi_rdata_o[0]
        |-> since_b_reg < 6'h3c)
        else $error("busy stuck");
    a_resp_code: assert property ($rose(s_axi_bvalid_o) |-> s_axi_bresp_o ==
        (wr_bad_reg ? `WDL_RESP_SLVERR : `WDL_RESP_OKAY))
        else $error("bad write response");
    // Debug input passes a synchroniser first
    a_lock_clear: assert property ($fell(lock_o) |-> debug_mode_i &&
        $past(debug_mode_i, 3))
        else $error("lock cleared outside debug");
    a_lock_rise: assert property ($rose(lock_o) |-> s_axi_bvalid_o ||
        $past(s_axi_bvalid_o) || (boot_done_i && !$past(boot_done_i, 10)))
        else $error("lock set unprompted");
    a_pulse_one: assert property (wdt_reset_o |=> !wdt_reset_o)
        else $error("reset pulse too long");
    a_dbg_quiet: assert property (debug_mode_i [*8] |=> !wdt_reset_o)
        else $error("reset during debug");
endmodule

bind wdl_watchdog_lock wdl_watchdog_lock_checker #(.ADDR_W(ADDR_W)) i_wdl_watchdog_lock_checker (
    .clk_i, .rst_b_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
    .debug_mode_i, .boot_done_i, .wdt_reset_o, .lock_o
);

//--- testbench/tb_wdl_watchdog_lock.sv
// Bench for the watchdog lock block.
// Assumes the bound checker; bready and rready stay high.
`timescale 1ns/1ns
`include "wdl_defs.svh"

module tb_wdl_watchdog_lock;
    localparam logic [7:0] A_CTL = {4'h0, `WDL_IDX_CTRL, 2'h0};
    localparam logic [7:0] A_STA = {4'h0, `WDL_IDX_STATUS, 2'h0};
    localparam logic [7:0] A_UNL = {4'h0, `WDL_IDX_UNLOCK, 2'h0};
    localparam logic [7:0] A_RST = {4'h0, `WDL_IDX_RESTART, 2'h0};
    localparam logic [7:0] A_BAD = 8'h10;

    logic        clk_i;
    logic        wdt_clk_i;
    logic        rst_b_i = 1'b0, s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic        s_axi_arvalid_i = 1'b0, debug_mode_i = 1'b0, boot_done_i = 1'b0;
    logic        s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
    logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, fuse_ctrl_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0]  s_axi_wstrb_i = 4'h1;
    logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic        s_axi_rvalid_o, wdt_reset_o, lock_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
    logic [31:0] s_axi_rdata_o, d;
    int          err_count = 0;
    int          n_tests = 0;
    int          pulses = 0;
    int          p0, n;

    wdl_watchdog_lock i_wdl_watchdog_lock (
        .clk_i, .rst_b_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
        .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
        .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i, .wdt_clk_i, .debug_mode_i,
        .boot_done_i, .fuse_ctrl_i, .wdt_reset_o, .lock_o
    );

    ////////////////////////////////////////
    // Clocks; each watchdog level spans many system cycles
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        wdt_clk_i = 1'b0;
        forever #20 wdt_clk_i = ~wdt_clk_i;
    end

    // Count watchdog reset pulses
    always @(posedge clk_i) begin
        if (wdt_reset_o === 1'b1) pulses <= pulses + 1;
    end

    ////////////////////////////////////////
    // Compare and closing tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_r(input string nm, input logic [1:0] e, input logic [1:0] g);
        chk(nm, 32'(e), 32'(g));
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////
    // Bus tasks; start after an edge, end on the answer edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
        logic aw = 1'b0;
        logic w  = 1'b0;
        s_axi_awaddr_i  <= a;
        s_axi_wdata_i   <= {24'h0, v};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_i);
            if (s_axi_awvalid_i && s_axi_awready_o === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid_i <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid_i <= 1'b0;
            end
        end
        while (s_axi_bvalid_o !== 1'b1) @(posedge clk_i);
        rs = s_axi_bresp_o;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        s_axi_araddr_i  <= a;
        s_axi_arvalid_i <= 1'b1;
        do @(posedge clk_i); while (s_axi_arready_o !== 1'b1);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
        v  = s_axi_rdata_o;
        rs = s_axi_rresp_o;
    endtask
    // Read, compare, expect OKAY
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        rd(a, d, r);
        chk(nm, e, d);
        chk_r(nm, `WDL_RESP_OKAY, r);
    endtask
    // Key, then the protected write while the window is open
    task automatic pw(input logic [7:0] a, input logic [7:0] v);
        wr(A_UNL, `WDL_UNLOCK_KEY, r);
        wr(a, v, r);
    endtask
    // Poll busy, bounded, after a control write
    task automatic idle();
        for (int i = 0; i < 30; i++) begin
            rd(A_STA, d, r);
            if (d[0] === 1'b0) break;
        end
        chk("busy clear", 32'h0, 32'(d[0]));
    endtask
    task automatic wait_pulse(output int c);
        c = 0;
        do begin
            @(posedge clk_i);
            c++;
        end while (wdt_reset_o !== 1'b1 && c < 3000);
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        rc("status reset", A_STA, 32'h00);
        wr(A_CTL, 8'h21, r);
        rc("ctrl no key", A_CTL, 32'h00);
        pw(A_CTL, 8'h21);
        rc("busy set", A_STA, 32'h01);
        idle();
        rc("ctrl written", A_CTL, 32'h21);
        pw(A_STA, 8'h81);
        rc("lock set", A_STA, 32'h80);
        chk("lock out", 32'h1, 32'(lock_o));
        pw(A_CTL, 8'h03);
        rc("ctrl locked", A_CTL, 32'h21);
        rc("no busy", A_STA, 32'h80);
        pw(A_STA, 8'h00);
        rc("lock kept", A_STA, 32'h80);
        wr(A_BAD, 8'h00, r);
        chk_r("wr unmapped", `WDL_RESP_SLVERR, r);
        rd(A_BAD, d, r);
        chk_r("rd unmapped", `WDL_RESP_SLVERR, r);
        debug_mode_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        pw(A_STA, 8'h00);
        rc("lock cleared", A_STA, 32'h00);
        debug_mode_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        p0 = pulses;
        wr(A_RST, 8'h01, r);
        wr(A_RST, 8'h01, r);
        repeat (100) @(posedge clk_i);
        chk("second restart", 32'(p0), 32'(pulses));
        wr(A_RST, 8'h01, r);
        repeat (40) @(posedge clk_i);
        chk("closed restart", 32'(p0 + 1), 32'(pulses));
        pw(A_CTL, 8'h06);
        idle();
        wait_pulse(n);
        wait_pulse(n);
        chk("256 tick period", 32'h1, 32'(n >= 2550 && n <= 2570));
        // Reset with a non-zero fuse period
        fuse_ctrl_i <= 8'h01;
        rst_b_i     <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        rc("ctrl from fuse", A_CTL, 32'h01);
        boot_done_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        chk("boot lock", 32'h1, 32'(lock_o));
        close_out();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        close_out();
    end
endmodule
